// File: pkg/wd_pkg.sv
// Shared constants, register map and helpers for the watchdog block
package wd_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_CONTROL = 8'h00; // Counter and activation
  localparam logic [7:0] ADDR_CONFIG = 8'h04; // Timebase select and RTC interrupt enable
  localparam logic [7:0] ADDR_STATUS = 8'h08; // Read-only block state

  // Control register layout and reset value
  localparam int ACT_BIT = 7; // Activation bit position
  localparam int GUARD_BIT = 6; // Counter guard bit position
  localparam int COUNT_WIDTH = 7; // Width of the downcounter
  localparam logic [7:0] CONTROL_RESET = 8'h7F; // Disabled, counter full
  localparam logic [6:0] ROLL_FROM = 7'h40; // Value that rolls into expiry

  // Config register layout and reset value
  localparam int TB_LSB = 0; // Timebase select, two bits
  localparam int RTC_IE_BIT = 2; // RTC interrupt enable
  localparam logic [2:0] CONFIG_RESET = 3'h0;

  // Status register layout
  localparam int ST_STATE_LSB = 0; // Three bits of power state
  localparam int ST_ACTIVE_BIT = 3; // Watchdog active (software or option)
  localparam int ST_RESET_BIT = 4; // Reset request raised

  // Timing counts in oscillator periods
  localparam int TICK_PERIOD = 16384; // Normal decrement interval
  localparam int LONG_BASE = 192; // Long interval base, in units
  localparam int LONG_UNIT = 64; // Long interval unit
  localparam int DELAY_SHORT = 256; // Short restart delay in CPU clocks
  localparam int DELAY_LONG = 4096; // Long restart delay in CPU clocks
  localparam int PRE_WIDTH = 15; // Prescaler counter width

  // Power states of the watchdog
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_ONE,
    ST_HALTED,
    ST_ACTIVE_HALT,
    ST_RESTART
  } pstate_t;

  // MSB constant of each timebase
  function automatic logic [5:0] tb_msb(input logic [1:0] tb);
    case (tb)
      2'b00: tb_msb = 6'd4;
      2'b01: tb_msb = 6'd8;
      2'b10: tb_msb = 6'd20;
      default: tb_msb = 6'd49;
    endcase
  endfunction

  // LSB constant of each timebase
  function automatic logic [5:0] tb_lsb(input logic [1:0] tb);
    case (tb)
      2'b00: tb_lsb = 6'd59;
      2'b01: tb_lsb = 6'd53;
      2'b10: tb_lsb = 6'd35;
      default: tb_lsb = 6'd54;
    endcase
  endfunction

endpackage

// File: rtl/wd_prescaler.sv
// Shared oscillator prescaler that paces the watchdog decrements
`timescale 1ns/100ps
module wd_prescaler
  import wd_pkg::*;
#(
  parameter int WIDTH = PRE_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] timebase_select,
  output logic tick
);

  logic [WIDTH-1:0] count; // Cycles into the current interval
  logic [5:0] phase; // Decrements since the last long interval
  logic [WIDTH-1:0] next_count;
  logic [5:0] next_phase;
  logic next_tick;
  logic [5:0] group; // Decrements per long interval
  logic [WIDTH-1:0] last; // Last cycle index of this interval

  // Interval length: one long interval in each group, integer division
  always_comb begin
    group = tb_msb(timebase_select) >> 2;
    if (group != 6'd0 && phase == group - 6'd1) begin
      last = WIDTH'((LONG_BASE + int'(tb_lsb(timebase_select))) * LONG_UNIT - 1);
    end else begin
      last = WIDTH'(TICK_PERIOD - 1);
    end
    next_count = count;
    next_phase = phase;
    next_tick = 1'b0;
    // A restart begins a fresh interval and wins over a coincident tick
    if (restart) begin
      next_count = '0;
    end else if (run) begin
      if (count >= last) begin
        next_count = '0;
        next_tick = 1'b1;
        next_phase = (phase + 6'd1 >= group) ? 6'd0 : phase + 6'd1;
      end else begin
        next_count = count + WIDTH'(1);
      end
    end
  end

  // Register the prescaler state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      phase <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
      tick <= next_tick;
    end
  end

endmodule

// File: rtl/wd_restart_delay.sv
// Restart delay of 256 or 4096 CPU clocks before counting resumes
`timescale 1ns/100ps
module wd_restart_delay
  import wd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic long_sel,
  output logic done
);

  logic [12:0] remain; // Clocks still to wait
  logic busy; // Delay in progress
  logic [12:0] next_remain;
  logic next_busy;
  logic next_done;

  // Load on start, count down, pulse done at the end
  always_comb begin
    next_remain = remain;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      // Two clocks go to the launch edge and the done pulse
      next_remain = long_sel ? 13'(DELAY_LONG - 2) : 13'(DELAY_SHORT - 2);
      next_busy = 1'b1;
    end else if (busy) begin
      if (remain == 13'h0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_remain = remain - 13'h1;
      end
    end
  end

  // Register the delay state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      remain <= next_remain;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule

// File: rtl/wd_timer.sv
// Watchdog timer with low-power behaviour and an APB register port
//
// Behaviour
// - First decrement within prescaler phase window
// - One long interval per msb/4 decrements
// - Timebase codes select msb and lsb pairs
// - Interval divisions truncate toward zero
// - Slow and wait modes change nothing
// - Plain halt decrements once, then stops
// - External wake restarts after selected delay
// - Reset disables unless hardware option set
// - Halt with halt-reset option and RTC enable clear raises reset
// - Halt with RTC enable enters active-halt
// - Interrupt wake from active-halt restarts immediately
// - Reset restart waits the selected delay
// - Hardware option keeps watchdog always active
// - Active rollover 40h to 3Fh requests reset
// - Counter free-runs about every 16384 cycles
// - Reset disables; only reset clears activation
// - Writing activation with guard clear resets
`timescale 1ns/100ps
module wd_timer
  import wd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_watchdog_opt,
  input wire logic halt_reset_option,
  input wire logic long_restart_sel,
  input wire logic halt_req,
  input wire logic ext_wake,
  input wire logic osc_wake,
  output logic wd_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic activation_bit; // Software activation, sticky until reset
  logic [6:0] loaded_count; // The downcounter
  logic [1:0] timebase_select; // Shared timebase choice
  logic rtc_irq_enable; // RTC interrupt enable
  pstate_t state; // Power state of the watchdog
  logic opt_hw; // Captured hardware watchdog option
  logic opt_halt; // Captured halt-reset option
  logic opt_long; // Captured restart delay choice
  logic opt_taken; // Options have been captured

  logic next_activation_bit;
  logic [6:0] next_loaded_count;
  logic [1:0] next_timebase_select;
  logic next_rtc_irq_enable;
  pstate_t next_state;
  logic next_wd_reset_req;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic tick; // Decrement strobe from the prescaler
  logic delay_done; // Restart delay has elapsed
  logic delay_start; // Launch a restart delay
  logic active; // Watchdog may raise a reset
  logic apb_done; // Access phase completes this edge
  logic wr_ctrl; // Write to the control register
  logic wr_cfg; // Write to the config register
  logic decrement; // Counter steps down this edge
  logic mapped; // Address hits a register
  logic start_after_reset; // First cycle after reset release
  logic delay_long; // Restart delay choice in force

  ////////////////////////////////////////////////////////////////////////////
  // Option capture

  // Straps are caught by a clocked process after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_hw <= 1'b0;
      opt_halt <= 1'b0;
      opt_long <= 1'b0;
      opt_taken <= 1'b0;
    end else if (!opt_taken) begin
      opt_hw <= hw_watchdog_opt;
      opt_halt <= halt_reset_option;
      opt_long <= long_restart_sel;
      opt_taken <= 1'b1;
    end
  end

  assign start_after_reset = !opt_taken;

  // The strap is read directly until it has been captured
  assign delay_long = opt_taken ? opt_long : long_restart_sel;

  // Effective activation: software bit or hardware option
  assign active = activation_bit || opt_hw;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  // Prescaler is shared with the RTC, frozen only in plain halt
  // A control write restarts the interval so the first decrement lands in its window
  wd_prescaler #(
    .WIDTH(PRE_WIDTH)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(state != ST_HALTED),
    .restart(wr_ctrl),
    .timebase_select(timebase_select),
    .tick(tick)
  );

  // Restart delay after an external wake or a reset
  wd_restart_delay u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(delay_start),
    .long_sel(delay_long),
    .done(delay_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign apb_done = psel && penable && pready;
  assign wr_ctrl = apb_done && pwrite && paddr == ADDR_CONTROL;
  assign wr_cfg = apb_done && pwrite && paddr == ADDR_CONFIG;
  assign mapped = paddr == ADDR_CONTROL || paddr == ADDR_CONFIG || paddr == ADDR_STATUS;

  // Bus answer: pready rises one cycle into the access phase
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !mapped;
    next_prdata = prdata;
    if (psel && penable && !pready) begin
      case (paddr)
        ADDR_CONTROL: next_prdata = {24'h0000_00, activation_bit, loaded_count};
        ADDR_CONFIG: next_prdata = {29'h0000_0000, rtc_irq_enable, timebase_select};
        ADDR_STATUS: next_prdata = {27'h0000_000, wd_reset_req, active, 3'(state)};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register the bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine

  // Slow and wait are not inputs at all, so the counter is unaffected
  always_comb begin
    next_state = state;
    delay_start = 1'b0;
    case (state)
      // Normal counting
      ST_RUN: begin
        if (halt_req) begin
          if (rtc_irq_enable) begin
            next_state = ST_ACTIVE_HALT;
          end else if (!opt_halt) begin
            next_state = ST_HALT_ONE;
          end
        end
      end
      // One more decrement, then stop
      ST_HALT_ONE: begin
        if (ext_wake) begin
          next_state = ST_RESTART;
          delay_start = 1'b1;
        end else if (tick) begin
          next_state = ST_HALTED;
        end
      end
      // Stopped until an external interrupt
      ST_HALTED: begin
        if (ext_wake) begin
          next_state = ST_RESTART;
          delay_start = 1'b1;
        end
      end
      // Counter stopped, prescaler runs on
      ST_ACTIVE_HALT: begin
        if (ext_wake || osc_wake) begin
          next_state = ST_RUN;
        end
      end
      // Waiting out the restart delay
      ST_RESTART: begin
        if (start_after_reset) begin
          delay_start = 1'b1;
        end else if (delay_done) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, control and config

  // Counts in run and in the single halt step, whether active or not
  assign decrement = tick && (state == ST_RUN || state == ST_HALT_ONE);

  // A control write reloads the counter; it wins over a coincident decrement
  always_comb begin
    next_activation_bit = activation_bit;
    next_loaded_count = loaded_count;
    next_timebase_select = timebase_select;
    next_rtc_irq_enable = rtc_irq_enable;
    next_wd_reset_req = wd_reset_req;
    if (wr_ctrl) begin
      next_activation_bit = activation_bit || pwdata[ACT_BIT];
      next_loaded_count = pwdata[COUNT_WIDTH-1:0];
      if ((activation_bit || pwdata[ACT_BIT] || opt_hw) && !pwdata[GUARD_BIT]) begin
        next_wd_reset_req = 1'b1;
      end
    end else if (decrement) begin
      next_loaded_count = loaded_count - 7'h01;
      if (active && loaded_count == ROLL_FROM) begin
        next_wd_reset_req = 1'b1;
      end
    end
    if (wr_cfg) begin
      next_timebase_select = pwdata[TB_LSB +: 2];
      next_rtc_irq_enable = pwdata[RTC_IE_BIT];
    end
    if (state == ST_RUN && halt_req && !rtc_irq_enable && opt_halt) begin
      next_wd_reset_req = 1'b1;
    end
  end

  // Register the watchdog state; the reset request holds until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activation_bit <= CONTROL_RESET[ACT_BIT];
      loaded_count <= CONTROL_RESET[COUNT_WIDTH-1:0];
      timebase_select <= CONFIG_RESET[TB_LSB +: 2];
      rtc_irq_enable <= CONFIG_RESET[RTC_IE_BIT];
      state <= ST_RESTART;
      wd_reset_req <= 1'b0;
    end else begin
      activation_bit <= next_activation_bit;
      loaded_count <= next_loaded_count;
      timebase_select <= next_timebase_select;
      rtc_irq_enable <= next_rtc_irq_enable;
      state <= next_state;
      wd_reset_req <= next_wd_reset_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_guard_write_reset: assert property (
    wr_ctrl && pwdata[ACT_BIT] && !pwdata[GUARD_BIT] |=> wd_reset_req)
    else $error("guard-clear write did not raise reset");

  a_rollover_reset: assert property (
    decrement && !wr_ctrl && active && loaded_count == ROLL_FROM |=> wd_reset_req && loaded_count == 7'h3F)
    else $error("rollover to 3Fh did not raise reset");

  a_inactive_no_reset: assert property (
    decrement && !wr_ctrl && !active && !wd_reset_req && !(halt_req && opt_halt) |=> !wd_reset_req)
    else $error("inactive watchdog raised reset");

  a_activation_sticky: assert property (
    activation_bit |=> activation_bit)
    else $error("activation bit cleared without reset");

  a_hw_always_active: assert property (
    opt_taken && opt_hw |-> active)
    else $error("hardware option did not keep watchdog active");

  a_halt_option_reset: assert property (
    state == ST_RUN && halt_req && !rtc_irq_enable && opt_halt |=> wd_reset_req)
    else $error("halt with halt-reset option gave no reset");

  a_active_halt_enter: assert property (
    state == ST_RUN && halt_req && rtc_irq_enable |=> state == ST_ACTIVE_HALT && $stable(wd_reset_req))
    else $error("halt with RTC enable did not enter active-halt");

  a_active_halt_frozen: assert property (
    state == ST_ACTIVE_HALT && !wr_ctrl |=> loaded_count == $past(loaded_count))
    else $error("counter moved in active-halt");

  a_wake_immediate: assert property (
    state == ST_ACTIVE_HALT && (osc_wake || ext_wake) |=> state == ST_RUN)
    else $error("active-halt wake was delayed");

  a_halt_restart_delay: assert property (
    state == ST_HALTED && ext_wake && !opt_long |=> state == ST_RESTART ##256 state == ST_RUN)
    else $error("halt wake restart delay wrong");

  a_halted_stopped: assert property (
    state == ST_HALTED && !ext_wake && !wr_ctrl |=> $stable(loaded_count))
    else $error("counter moved in halt");

  a_pready_single: assert property (
    pready |=> !pready)
    else $error("pready held more than one cycle");

  a_restart_to_run: assert property (
    state == ST_RESTART && !start_after_reset && delay_done |=> state == ST_RUN)
    else $error("restart delay end did not resume counting");

  a_halt_one_step: assert property (
    state == ST_HALT_ONE && tick && !ext_wake && !wr_ctrl |=> state == ST_HALTED && loaded_count == $past(loaded_count) - 7'h01)
    else $error("plain halt did not take exactly one decrement");

  a_unmapped_error: assert property (
    psel && penable && !pready && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access gave no error");

  c_rollover: cover property (decrement && active && loaded_count == ROLL_FROM);
  c_active_halt_wake: cover property (state == ST_ACTIVE_HALT ##1 state == ST_RUN);
  c_halt_restart: cover property (state == ST_HALTED ##1 state == ST_RESTART);
  c_sw_reset: cover property (wr_ctrl && pwdata[ACT_BIT] && !pwdata[GUARD_BIT]);
  c_reset_restart: cover property (state == ST_RESTART ##1 state == ST_RUN);

endmodule

// File: verification/tb.sv
// Self-checking testbench for the watchdog timer block
`timescale 1ns/100ps
module tb
  import wd_pkg::*;
;
  ////////////////////////////////////////////////////////////////
  logic pclk = 1'b0; // Bus, oscillator and CPU clock
  logic presetn = 1'b0; // Active-low reset
  logic psel = 1'b0; // Bus master signals
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata; // Slave answer
  logic pready;
  logic pslverr;
  logic hw_opt = 1'b0; // Option straps
  logic halt_opt = 1'b0;
  logic long_sel = 1'b0;
  logic [2:0] ev = 3'h0; // Pulses: halt, external wake, oscillator wake
  logic wd_reset_req; // Reset request from the block
  int n_fail = 0; // Mismatches
  int n_compared = 0; // Comparisons made
  int cyc = 0; // Free-running cycle count
  int t_mark = 0; // Start of a timed span
  logic [31:0] rd; // Last read data
  logic er; // Last error flag

  ////////////////////////////////////////////////////////////////
  // Clock of 5 ns period
  always #2.5 pclk = ~pclk;

  // Cycle count, updated after the edge so readers see a stable value
  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  wd_timer dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hw_watchdog_opt(hw_opt),
    .halt_reset_option(halt_opt),
    .long_restart_sel(long_sel),
    .halt_req(ev[0]),
    .ext_wake(ev[1]),
    .osc_wake(ev[2]),
    .wd_reset_req(wd_reset_req)
  );

  ////////////////////////////////////////////////////////////////
  // Compare one value, report and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Compare a single flag
  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  // Check that a measured span lies in a window
  task automatic check_in(input int v, input int lo, input int hi);
    if (v < lo || v > hi) begin
      $display("Span %0d outside %0d..%0d", v, lo, hi);
    end
    check1(v >= lo && v <= hi, 1'b1);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One bus transfer: setup, access until ready, release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until ready is seen at an edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      check1(1'b0, 1'b1);
    end
  endtask

  // One-cycle pulse on a power event input
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask

  // Poll status until the power state matches, bounded
  task automatic wait_state(input logic [2:0] s, output int t);
    do begin
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    end while (rd[2:0] !== s && cyc - t_mark < 40000);
    t = cyc - t_mark;
  endtask

  // Poll the counter until it reaches a value, bounded
  task automatic wait_count(input logic [6:0] c, output int t);
    do begin
      apb(ADDR_CONTROL, 1'b0, 32'h0000_0000);
    end while (rd[6:0] !== c && cyc - t_mark < 40000);
    t = cyc - t_mark;
  endtask

  // Reset for 12 cycles with the given straps
  task automatic do_reset(input logic h, input logic o, input logic l);
    @(posedge pclk);
    presetn <= 1'b0;
    hw_opt <= h;
    halt_opt <= o;
    long_sel <= l;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_mark = cyc;
  endtask

  ////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  // Main sequence
  initial begin
    int t;
    do_reset(1'b0, 1'b0, 1'b0);
    // Reset values and an unmapped address
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    apb(ADDR_CONTROL, 1'b0, 32'h0000_0000);
    check(rd, {24'h0, CONTROL_RESET});
    apb(ADDR_CONFIG, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(8'h0C, 1'b0, 32'h0000_0000);
    check1(er, 1'b1);
    check(rd, 32'h0000_0000);
    wait_state(ST_RUN, t);
    check_in(t, DELAY_SHORT, DELAY_SHORT + 14);
    // Every timebase code is accepted
    for (int i = 0; i < 4; i++) begin
      apb(ADDR_CONFIG, 1'b1, 32'(i));
      apb(ADDR_CONFIG, 1'b0, 32'h0000_0000);
      check(rd, 32'(i));
    end
    // Plain halt: one decrement, then stopped until external wake
    apb(ADDR_CONFIG, 1'b1, 32'h0000_0000);
    apb(ADDR_CONTROL, 1'b1, 32'h0000_007F);
    pulse(0);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    t_mark = cyc;
    wait_state(ST_HALTED, t);
    apb(ADDR_CONTROL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_007E);
    check1(wd_reset_req, 1'b0);
    pulse(1);
    t_mark = cyc;
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    wait_state(ST_RUN, t);
    check_in(t, DELAY_SHORT, DELAY_SHORT + 14);
    // Active halt, left by either wake without delay
    apb(ADDR_CONFIG, 1'b1, 32'h0000_0004);
    pulse(0);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    pulse(2);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    pulse(0);
    pulse(1);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Decrement timing on timebase 0, watchdog not active
    apb(ADDR_CONFIG, 1'b1, 32'h0000_0000);
    apb(ADDR_CONTROL, 1'b1, 32'h0000_007F);
    t_mark = cyc;
    wait_count(7'h7E, t);
    check_in(t, (59 + 128) * LONG_UNIT, TICK_PERIOD + 8);
    t_mark = cyc;
    wait_count(7'h7D, t);
    check_in(t, (LONG_BASE + 59) * LONG_UNIT - 8, (LONG_BASE + 59) * LONG_UNIT + 8);
    check1(wd_reset_req, 1'b0);
    // Activation is sticky, then rollover 40h to 3Fh requests reset
    apb(ADDR_CONTROL, 1'b1, 32'h0000_00C0);
    apb(ADDR_CONTROL, 1'b1, 32'h0000_0040);
    t_mark = cyc;
    apb(ADDR_CONTROL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_00C0);
    while (wd_reset_req !== 1'b1 && cyc - t_mark < 20000) begin
      @(posedge pclk);
    end
    check_in(cyc - t_mark, (59 + 128) * LONG_UNIT, TICK_PERIOD + 8);
    // Reset disables again; guard-clear write resets at once
    do_reset(1'b0, 1'b0, 1'b0);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    apb(ADDR_CONTROL, 1'b1, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    check1(wd_reset_req, 1'b1);
    // Hardware option, long restart and halt-reset option
    do_reset(1'b1, 1'b1, 1'b1);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_000C);
    wait_state(ST_RUN, t);
    check_in(t, DELAY_LONG, DELAY_LONG + 14);
    check1(wd_reset_req, 1'b0);
    pulse(0);
    repeat (2) @(posedge pclk);
    check1(wd_reset_req, 1'b1);
    wrap_up();
  end
endmodule
